//--- design/epc_arb_if.sv
/*
  Carrier between the controller and its arbiter: request mask with
  ranks in, winning position and rank out.
  Assumes the arbiter registers its answer.
*/
`timescale 1ns/1ps
interface epc_arb_if;
  logic [55:0]      req;
  logic [55:0][3:0] rank;
  logic             v;
  logic [5:0]       idx;
  logic [3:0]       win_rank;
  modport arb  (input req, rank, output v, idx, win_rank);
  modport user (output req, rank, input v, idx, win_rank);
endinterface

//--- design/epc_arbiter.sv
/*
  Registered arbiter: most urgent requested source, lowest position
  on equal rank. Answer lags its inputs by one clock.
  Assumes synchronous inputs on the one system clock.
*/
`timescale 1ns/1ps
module epc_arbiter (
  input  wire logic  clk,
  input  wire logic  rst,
  epc_arb_if.arb     bus
);
  typedef struct packed {
    logic       v;
    logic [5:0] idx;
    logic [3:0] rank;
  } epc_arb_s;

  epc_arb_s         s_r;
  epc_arb_s         s_nxt;
  logic [55:0]      req_q;
  logic [55:0][3:0] rank_q;
  logic             better;

  // Descending scan: on equal rank the lower position wins
  always_comb begin
    s_nxt = '{v: 1'b0, idx: 6'h00, rank: epc_pkg::RANK_NONE};
    for (int i = epc_pkg::NSRC - 1; i >= 0; i--) begin
      if (bus.req[i] && bus.rank[i] <= s_nxt.rank) begin
        s_nxt.v    = 1'b1;
        s_nxt.idx  = 6'(i);
        s_nxt.rank = bus.rank[i];
      end
    end
  end

  // Winner register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.v        = s_r.v;
  assign bus.idx      = s_r.idx;
  assign bus.win_rank = s_r.rank;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_q  <= '0;
      rank_q <= '0;
    end else begin
      req_q  <= bus.req;
      rank_q <= bus.rank;
    end
  end

  always_comb begin
    better = 1'b0;
    for (int j = 0; j < epc_pkg::NSRC; j++) begin
      if (req_q[j] && (rank_q[j] < s_r.rank ||
          (rank_q[j] == s_r.rank && 6'(j) < s_r.idx))) begin
        better = 1'b1;
      end
    end
  end

  chk_tie_order: assert property (
    @(posedge clk) disable iff (rst) s_r.v |-> !better)
    else $error("arbiter passed over a more urgent or lower source");

  chk_win_pending: assert property (
    @(posedge clk) disable iff (rst)
    s_r.v |-> req_q[s_r.idx] && rank_q[s_r.idx] == s_r.rank)
    else $error("arbiter chose a source that was not requesting");

endmodule

//--- design/epc_pkg.sv
/*
  Shared constants and types for the exception priority controller:
  source positions, rank encoding, register offsets and field positions,
  sequencer states and the rank group helper function.
  Assumes 32-bit AHB-Lite word registers and one 25 MHz clock.
*/
package epc_pkg;

  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int NSRC = 56;
  localparam int NIRQ = 40;

  // ------------------------------------------------------------
  // Source positions
  // ------------------------------------------------------------
  localparam logic [5:0] POS_RESET  = 6'h01;
  localparam logic [5:0] POS_NMI    = 6'h02;
  localparam logic [5:0] POS_HARD   = 6'h03;
  localparam logic [5:0] POS_MEM    = 6'h04;
  localparam logic [5:0] POS_BUS    = 6'h05;
  localparam logic [5:0] POS_USAGE  = 6'h06;
  localparam logic [5:0] POS_SVC    = 6'h0b;
  localparam logic [5:0] POS_DBG    = 6'h0c;
  localparam logic [5:0] POS_PENDABLE_SERVICE_REQUEST = 6'h0e;
  localparam logic [5:0] POS_TICK   = 6'h0f;
  localparam logic [5:0] POS_IRQ0   = 6'h10;
  // Settable system handlers, slot 0 last
  localparam logic [6:0][5:0] SYS_POS = {POS_TICK, POS_PENDABLE_SERVICE_REQUEST, POS_DBG,
    POS_SVC, POS_USAGE, POS_BUS, POS_MEM};
  // Implemented peripheral lines; every other bit is reserved
  localparam logic [39:0] IRQ_IMPL = 40'h81_f07f_c1ff;

  // ------------------------------------------------------------
  // Ranks: lower is more urgent
  // ------------------------------------------------------------
  localparam logic [3:0] RANK_NMI  = 4'h1;
  localparam logic [3:0] RANK_HARD = 4'h2;
  localparam logic [3:0] RANK_SET0 = 4'h3;
  localparam logic [3:0] RANK_NONE = 4'hf;
  localparam logic [2:0] PRIO_RST  = 3'h0;

  // ------------------------------------------------------------
  // Register offsets and fields
  // ------------------------------------------------------------
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_GROUP   = 8'h04;
  localparam logic [7:0] A_HEN     = 8'h08;
  localparam logic [7:0] A_SYSP    = 8'h0c;
  localparam logic [7:0] A_EN_LO   = 8'h10;
  localparam logic [7:0] A_EN_HI   = 8'h14;
  localparam logic [7:0] A_PEND_LO = 8'h18;
  localparam logic [7:0] A_PEND_HI = 8'h1c;
  localparam logic [7:0] A_IPR0    = 8'h20;
  localparam int CTRL_NMI     = 0;
  localparam int CTRL_PSV_SET = 1;
  localparam int CTRL_PSV_CLR = 2;
  localparam int EN_DBG       = 3;

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  localparam logic [3:0] STACK_LAST  = 4'h7;  // Eight words
  localparam logic [3:0] SETTLE_LAST = 4'h1;  // Two cycles
  typedef enum logic [2:0] {ST_BOOT, ST_RUN, ST_STACK, ST_SETTLE,
    ST_RET, ST_TAIL, ST_UNSTACK} epc_st_e;

  // Pre-emption group of a rank; low sub bits do not pre-empt
  function automatic logic [3:0] grp(input logic [3:0] r,
                                     input logic [1:0] sub);
    logic [2:0] p;
    p = 3'(r - RANK_SET0);
    if (r < RANK_SET0 || r == RANK_NONE) return r;
    return RANK_SET0 + {1'b0, 3'((p >> sub) << sub)};
  endfunction

endpackage

//--- design/epc_top.sv
/*
  Exception priority controller: pending and active state for fixed
  and settable exceptions and 40 peripheral lines, pre-emption with
  grouping, entry, return and tail-chain sequencing toward the core,
  and an AHB-Lite register slave.
  Assumes all event inputs are synchronous one-clock pulses or levels
  on CLOCK, and a master that issues single word transfers.
*/
// Our own choices: the register addresses and the AHB-Lite register port.
// Notes on behaviour
// - eight levels for seven handlers, 24 lines
// - settable zero ranks fourth, after three fixed
// - all settable priorities reset to zero
// - equal level, lowest position goes first
// - stack state on entry, unstack on return
// - vector fetch overlaps first stacking cycle
// - pending at return chains without unstacking
// - handlers always run in handler mode
// - group bits pre-empt, subpriority only orders
// - reset is position 1, then base level
// - NMI position 2, only reset beats it
// - NMI pends only by software register write
// - blocked or disabled faults become hard fault
// - memory fault position 4, settable, synchronous
// - bus fault position 5, settable, enableable
// - usage fault position 6, settable
// - service call position 11, settable
// - debug monitor 12, enabled, not halting
// - pendable service 14, software pended only
// - system tick 15 pends on timer fire
// - peripherals from 16; 7-10, 13 reserved
// - peripheral bit map; other bits reserved
`timescale 1ns/1ps
module epc_top (
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output wire logic [31:0] HRDATA,
  output wire logic        HREADYOUT,
  output wire logic        HRESP,
  input  wire logic [39:0] IRQ_IN,
  input  wire logic        MEM_FAULT,
  input  wire logic        BUS_FAULT_PRECISE,
  input  wire logic        BUS_FAULT_IMPRECISE,
  input  wire logic        USAGE_FAULT,
  input  wire logic        SVC_EXEC,
  input  wire logic        DBG_MON_REQ,
  input  wire logic        DBG_HALTED,
  input  wire logic        TICK_FIRE,
  input  wire logic        HANDLER_DONE,
  output wire logic        STACK_PUSH,
  output wire logic        STACK_POP,
  output wire logic        VEC_FETCH,
  output wire logic [5:0]  VEC_NUM,
  output wire logic [5:0]  EXC_NUM,
  output wire logic        HANDLER_MODE
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    epc_pkg::epc_st_e  st;
    logic [3:0]        cnt;
    logic [5:0]        vec;
    logic              hm;
    logic              a_v;
    logic              a_wr;
    logic [7:0]        a_off;
    logic [31:0]       rdata;
    logic [1:0]        sub;
    logic [3:0]        hen;
    logic [6:0][2:0]   sysp;
    logic [39:0][2:0]  irq_pr;
    logic [39:0]       irq_en;
    logic [55:0]       pend;
    logic [55:0]       act;
  } epc_top_s;

  epc_top_s          s_r;
  epc_top_s          s_nxt;
  logic [55:0]       p_set;
  logic [55:0]       p_clr;
  logic [55:0]       a_set;
  logic [55:0]       a_clr;
  logic [55:0][3:0]  rank;
  logic [31:0]       rd;
  logic [2:0]        flt;
  logic [3:0]        cgrp;
  logic [5:0]        exc_num;
  logic              pre;
  logic              take;
  logic              wr;
  logic              nmi_wr;
  logic              prio_wr;
  logic              prio_seen;

  epc_arb_if u_pend_if ();
  epc_arb_if u_cur_if ();

  epc_arbiter u_pend (
    .clk (CLOCK),
    .rst (SYS_RST),
    .bus (u_pend_if.arb)
  );

  epc_arbiter u_cur (
    .clk (CLOCK),
    .rst (SYS_RST),
    .bus (u_cur_if.arb)
  );

  // ------------------------------------------------------------
  // Rank table and arbitration inputs
  // ------------------------------------------------------------
  // Reserved system and reset positions keep the idle rank and never request
  always_comb begin
    rank = {epc_pkg::NSRC{epc_pkg::RANK_NONE}};
    rank[epc_pkg::POS_NMI]  = epc_pkg::RANK_NMI;
    rank[epc_pkg::POS_HARD] = epc_pkg::RANK_HARD;
    for (int k = 0; k < 7; k++) begin
      rank[epc_pkg::SYS_POS[k]] = epc_pkg::RANK_SET0 + {1'b0, s_r.sysp[k]};
    end
    for (int k = 0; k < epc_pkg::NIRQ; k++) begin
      rank[16 + k] = epc_pkg::RANK_SET0 + {1'b0, s_r.irq_pr[k]};
    end
  end

  // Disabled lines stay pending but do not compete
  assign u_pend_if.req  = s_r.pend &
                          {s_r.irq_en & epc_pkg::IRQ_IMPL, 16'hffff};
  assign u_pend_if.rank = rank;
  assign u_cur_if.req   = s_r.act;
  assign u_cur_if.rank  = rank;

  // Only the group part of the winner is weighed against the running one
  assign cgrp = u_cur_if.v ? epc_pkg::grp(u_cur_if.win_rank, s_r.sub)
                           : epc_pkg::RANK_NONE;
  assign pre  = u_pend_if.v &&
                epc_pkg::grp(u_pend_if.win_rank, s_r.sub) < cgrp;
  assign exc_num = (s_r.st == epc_pkg::ST_BOOT) ? epc_pkg::POS_RESET :
                   (u_cur_if.v ? u_cur_if.idx : 6'h00);
  assign flt = {USAGE_FAULT, BUS_FAULT_PRECISE || BUS_FAULT_IMPRECISE,
                MEM_FAULT};
  assign wr  = s_r.a_v && s_r.a_wr;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_nxt   = s_r;
    p_set   = '0;
    p_clr   = '0;
    a_set   = '0;
    a_clr   = '0;
    take    = 1'b0;
    nmi_wr  = 1'b0;
    prio_wr = 1'b0;
    rd      = '0;

    // Bus address phase: read data is captured here, so it stands
    // in a flip-flop for the whole data phase
    s_nxt.a_v = HSEL && HTRANS[1] && HREADY;
    if (s_nxt.a_v) begin
      s_nxt.a_wr  = HWRITE;
      s_nxt.a_off = HADDR[7:0];
    end
    case (HADDR[7:0])
      epc_pkg::A_CTRL:    rd = {15'h0000, s_r.hm, 2'h0, u_pend_if.idx,
                                2'h0, exc_num};
      epc_pkg::A_GROUP:   rd = {30'h0000_0000, s_r.sub};
      epc_pkg::A_HEN:     rd = {28'h000_0000, s_r.hen};
      epc_pkg::A_SYSP: begin
        for (int k = 0; k < 7; k++) rd[4 * k +: 3] = s_r.sysp[k];
      end
      epc_pkg::A_EN_LO:   rd = s_r.irq_en[31:0];
      epc_pkg::A_EN_HI:   rd = {24'h00_0000, s_r.irq_en[39:32]};
      epc_pkg::A_PEND_LO: rd = s_r.pend[47:16];
      epc_pkg::A_PEND_HI: rd = {24'h00_0000, s_r.pend[55:48]};
      default:            rd = '0;
    endcase
    for (int k = 0; k < epc_pkg::NIRQ; k++) begin
      if (HADDR[7:0] == epc_pkg::A_IPR0 + 8'(4 * (k / 8))) begin
        rd[4 * (k % 8) +: 3] = s_r.irq_pr[k];
      end
    end
    if (s_nxt.a_v && !HWRITE) s_nxt.rdata = rd;

    // Bus data phase writes; unmapped offsets are ignored
    if (wr) begin
      case (s_r.a_off)
        epc_pkg::A_CTRL: begin
          nmi_wr = HWDATA[epc_pkg::CTRL_NMI];
          p_set[epc_pkg::POS_NMI]    = nmi_wr;
          p_set[epc_pkg::POS_PENDABLE_SERVICE_REQUEST] = HWDATA[epc_pkg::CTRL_PSV_SET];
          p_clr[epc_pkg::POS_PENDABLE_SERVICE_REQUEST] = HWDATA[epc_pkg::CTRL_PSV_CLR];
        end
        epc_pkg::A_GROUP: s_nxt.sub = HWDATA[1:0];
        epc_pkg::A_HEN:   s_nxt.hen = HWDATA[3:0];
        epc_pkg::A_SYSP: begin
          prio_wr = 1'b1;
          for (int k = 0; k < 7; k++) s_nxt.sysp[k] = HWDATA[4 * k +: 3];
        end
        epc_pkg::A_EN_LO: s_nxt.irq_en[31:0] =
                            HWDATA & epc_pkg::IRQ_IMPL[31:0];
        epc_pkg::A_EN_HI: s_nxt.irq_en[39:32] =
                            HWDATA[7:0] & epc_pkg::IRQ_IMPL[39:32];
        epc_pkg::A_PEND_LO: p_set[47:16] = HWDATA & epc_pkg::IRQ_IMPL[31:0];
        epc_pkg::A_PEND_HI: p_set[55:48] =
                              HWDATA[7:0] & epc_pkg::IRQ_IMPL[39:32];
        default: ;
      endcase
      for (int k = 0; k < epc_pkg::NIRQ; k++) begin
        if (s_r.a_off == epc_pkg::A_IPR0 + 8'(4 * (k / 8))) begin
          prio_wr = 1'b1;
          s_nxt.irq_pr[k] = HWDATA[4 * (k % 8) +: 3];
        end
      end
    end

    // Faults that cannot pre-empt, or whose handler is off, escalate
    for (int k = 0; k < 3; k++) begin
      if (flt[k]) begin
        if (s_r.hen[k] &&
            epc_pkg::grp(rank[epc_pkg::POS_MEM + 6'(k)], s_r.sub) < cgrp)
        begin
          p_set[epc_pkg::POS_MEM + 6'(k)] = 1'b1;
        end else begin
          p_set[epc_pkg::POS_HARD] = 1'b1;
        end
      end
    end
    p_set[epc_pkg::POS_SVC]  = SVC_EXEC;
    p_set[epc_pkg::POS_DBG]  = DBG_MON_REQ && s_r.hen[epc_pkg::EN_DBG] &&
                               !DBG_HALTED;
    p_set[epc_pkg::POS_TICK] = TICK_FIRE;
    // A line already being serviced does not re-pend itself
    p_set[55:16] = p_set[55:16] |
                   (IRQ_IN & epc_pkg::IRQ_IMPL & ~s_r.act[55:16]);

    // Entry, return and tail-chain sequencing
    unique case (s_r.st)
      epc_pkg::ST_BOOT: s_nxt.st = epc_pkg::ST_RUN;
      epc_pkg::ST_RUN: begin
        if (HANDLER_DONE && s_r.hm) begin
          a_clr[u_cur_if.idx] = 1'b1;
          s_nxt.st  = epc_pkg::ST_RET;
          s_nxt.cnt = '0;
        end else if (pre) begin
          take      = 1'b1;
          s_nxt.st  = epc_pkg::ST_STACK;
          s_nxt.cnt = '0;
        end
      end
      epc_pkg::ST_STACK: begin
        if (s_r.cnt == 4'h0) s_nxt.hm = 1'b1;
        s_nxt.cnt = s_r.cnt + 4'h1;
        if (s_r.cnt == epc_pkg::STACK_LAST) begin
          s_nxt.st  = epc_pkg::ST_SETTLE;
          s_nxt.cnt = '0;
        end
      end
      epc_pkg::ST_SETTLE: begin
        s_nxt.cnt = s_r.cnt + 4'h1;
        if (s_r.cnt == epc_pkg::SETTLE_LAST) s_nxt.st = epc_pkg::ST_RUN;
      end
      epc_pkg::ST_RET: begin
        // Two cycles let both arbiters see the retired handler
        s_nxt.cnt = s_r.cnt + 4'h1;
        if (s_r.cnt == epc_pkg::SETTLE_LAST) begin
          s_nxt.cnt = '0;
          if (pre) begin
            take     = 1'b1;
            s_nxt.st = epc_pkg::ST_TAIL;
          end else begin
            s_nxt.st = epc_pkg::ST_UNSTACK;
          end
        end
      end
      epc_pkg::ST_TAIL: begin
        s_nxt.hm  = 1'b1;
        s_nxt.st  = epc_pkg::ST_SETTLE;
        s_nxt.cnt = '0;
      end
      epc_pkg::ST_UNSTACK: begin
        s_nxt.cnt = s_r.cnt + 4'h1;
        if (s_r.cnt == epc_pkg::STACK_LAST) begin
          s_nxt.hm  = u_cur_if.v;
          s_nxt.st  = epc_pkg::ST_RUN;
          s_nxt.cnt = '0;
        end
      end
    endcase

    if (take) begin
      p_clr[u_pend_if.idx] = 1'b1;
      a_set[u_pend_if.idx] = 1'b1;
      s_nxt.vec            = u_pend_if.idx;
    end
    // A new event in the clearing cycle survives
    s_nxt.pend = (s_r.pend & ~p_clr) | p_set;
    s_nxt.act  = (s_r.act & ~a_clr) | a_set;
  end

  // Settable priorities come up at level zero with the rest
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // The vector goes out with the first stacked word, not after
  assign STACK_PUSH   = s_r.st == epc_pkg::ST_STACK;
  assign STACK_POP    = s_r.st == epc_pkg::ST_UNSTACK;
  assign VEC_FETCH    = (STACK_PUSH && s_r.cnt == 4'h0) ||
                        s_r.st == epc_pkg::ST_TAIL;
  assign VEC_NUM      = s_r.vec;
  assign EXC_NUM      = exc_num;
  assign HANDLER_MODE = s_r.hm;
  assign HRDATA       = s_r.rdata;
  assign HREADYOUT    = 1'b1;
  assign HRESP        = 1'b0;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      prio_seen <= 1'b0;
    end else if (prio_wr) begin
      prio_seen <= 1'b1;
    end
  end

  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  sequence s_push8;
    STACK_PUSH [*8];
  endsequence

  chk_boot_level: assert property (
    s_r.st == epc_pkg::ST_BOOT |-> EXC_NUM == epc_pkg::POS_RESET
      ##1 s_r.st == epc_pkg::ST_RUN)
    else $error("reset level not left after one cycle");

  chk_push_burst: assert property (
    $rose(STACK_PUSH) |-> s_push8 ##1 !STACK_PUSH)
    else $error("stacking is not eight words");

  chk_fetch_parallel: assert property (
    $rose(STACK_PUSH) |-> VEC_FETCH)
    else $error("vector fetch not in first stacking cycle");

  chk_tail_direct: assert property (
    s_r.st == epc_pkg::ST_TAIL |-> VEC_FETCH && !STACK_POP &&
      !STACK_PUSH && $past(s_r.st == epc_pkg::ST_RET))
    else $error("tail chain touched the stack");

  chk_handler_mode: assert property (
    VEC_FETCH |=> HANDLER_MODE [*2])
    else $error("handler entered outside handler mode");

  chk_nmi_software: assert property (
    $rose(s_r.pend[epc_pkg::POS_NMI]) |-> $past(nmi_wr))
    else $error("NMI pended without a register write");

  chk_prio_reset: assert property (
    !prio_seen |-> s_r.sysp == '0 && s_r.irq_pr == '0)
    else $error("priority not zero before first write");

  chk_fault_escalate: assert property (
    MEM_FAULT && !s_r.hen[0] |=> s_r.pend[epc_pkg::POS_HARD] ||
      s_r.act[epc_pkg::POS_HARD])
    else $error("disabled memory fault did not escalate");

  chk_nmi_held: assert property (
    u_cur_if.v && u_cur_if.idx == epc_pkg::POS_NMI &&
      s_r.st == epc_pkg::ST_RUN |-> !pre)
    else $error("running NMI was pre-empted");

endmodule

//--- sim/epc_core_model.sv
/*
  Core model: ends each handler after a set idle spell.
  Assumes one clock and the controller's stack and fetch outputs.
*/
`timescale 1ns/1ps
module epc_core_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       busy,
  input  wire logic       mode,
  input  wire logic [7:0] dly,
  output logic            done
);
  logic [7:0] cnt_r;

  // Restart the spell on any stack or fetch activity, since an end
  // request before entry has settled would be ignored by the block
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 8'h00;
      done  <= 1'b0;
    end else begin
      done  <= mode && !busy && cnt_r == dly;
      cnt_r <= (busy || !mode || done) ? 8'h00 : cnt_r + 8'h01;
    end
  end
endmodule

//--- sim/exception_priority_controller_tb.sv
/*
  Self-checking bench for the exception priority controller.
  Assumes the core model beside it and single AHB-Lite word transfers.
*/
`timescale 1ns/1ps
module exception_priority_controller_tb;
  logic        CLOCK, SYS_RST, HSEL, HWRITE, halt;
  logic [31:0] HADDR, HWDATA, HRDATA;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE;
  logic [39:0] IRQ_IN;
  logic [6:0]  ev;
  logic [7:0]  dly;
  logic [5:0]  VEC_NUM, EXC_NUM;
  logic        HREADYOUT, HRESP, HANDLER_DONE, STACK_PUSH, STACK_POP;
  logic        VEC_FETCH, HANDLER_MODE;
  logic [5:0]  vt [7];
  int          n_errors, checked;

  epc_top dut (.CLOCK, .SYS_RST, .HSEL, .HADDR, .HTRANS, .HWRITE,
    .HSIZE, .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP,
    .IRQ_IN, .MEM_FAULT(ev[0]), .BUS_FAULT_PRECISE(ev[1]),
    .USAGE_FAULT(ev[2]), .SVC_EXEC(ev[3]), .DBG_MON_REQ(ev[4]),
    .TICK_FIRE(ev[5]), .BUS_FAULT_IMPRECISE(ev[6]), .DBG_HALTED(halt),
    .HANDLER_DONE, .STACK_PUSH, .STACK_POP, .VEC_FETCH, .VEC_NUM,
    .EXC_NUM, .HANDLER_MODE);
  epc_core_model core (.clk(CLOCK), .rst(SYS_RST), .dly,
    .busy(STACK_PUSH | STACK_POP | VEC_FETCH), .mode(HANDLER_MODE),
    .done(HANDLER_DONE));

  // -------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task conclude();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // One single transfer; leading edge gives the idle gap
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d,
           output logic [31:0] q);
    @(posedge CLOCK);
    HSEL   <= 1'b1;
    HADDR  <= {24'h0, a};
    HWRITE <= w;
    HTRANS <= 2'h2;
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
    HSEL   <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
    q = HRDATA;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    chk("rdata", e, q);
    chk("hresp", 0, HRESP);
  endtask

  task pulse(input logic [6:0] m, input logic [39:0] i);
    @(posedge CLOCK);
    ev     <= m;
    IRQ_IN <= i;
    @(posedge CLOCK);
    ev     <= 7'h0;
    IRQ_IN <= 40'h0;
  endtask

  // Entry: fetch overlaps first push, eight pushes, handler mode
  task take(input logic [5:0] v);
    int n;
    n = 0;
    #1;
    while (VEC_FETCH !== 1'b1 && n < 60) begin
      @(posedge CLOCK);
      #1;
      n++;
    end
    chk("vec", v, VEC_NUM);
    chk("push_at_fetch", 1, STACK_PUSH);
    n = 0;
    while (STACK_PUSH === 1'b1 && n < 20) begin
      @(posedge CLOCK);
      #1;
      n++;
    end
    chk("push_cycles", 8, n);
    chk("mode", 1, HANDLER_MODE);
    chk("exc", v, EXC_NUM);
  endtask

  // Tail chain: next fetch with no pop and no push between
  task chain(input logic [5:0] v);
    int   n;
    logic p;
    n = 0;
    p = 1'b0;
    #1;
    while (VEC_FETCH !== 1'b1 && n < 100) begin
      @(posedge CLOCK);
      #1;
      p |= STACK_POP === 1'b1;
      n++;
    end
    chk("vec", v, VEC_NUM);
    chk("pop_push", 0, {p, STACK_PUSH});
  endtask

  task idle();
    int n;
    n = 0;
    #1;
    while ((HANDLER_MODE !== 1'b0 || STACK_POP !== 1'b0) && n < 400) begin
      @(posedge CLOCK);
      #1;
      n++;
    end
    chk("exc_base", 0, EXC_NUM);
  endtask

  task quiet();
    logic s;
    s = 1'b0;
    repeat (10) begin
      @(posedge CLOCK);
      #1;
      s |= VEC_FETCH === 1'b1;
    end
    chk("no_fetch", 0, s);
  endtask

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task t_reset();
    rd(epc_pkg::A_SYSP, 0);
    rd(epc_pkg::A_IPR0, 0);
    rd(epc_pkg::A_GROUP, 0);
    rd(8'h40, 0);
  endtask

  // Disabled handler escalates, then each source at its position
  task t_faults();
    pulse(7'h01, 40'h0);
    take(6'h03);
    idle();
    wr(epc_pkg::A_HEN, 32'hf);
    for (int k = 0; k < 7; k++) begin
      pulse(7'h01 << k, 40'h0);
      take(vt[k]);
      idle();
    end
  endtask

  task t_tie(input logic [31:0] ipr, input logic [5:0] a, b);
    wr(epc_pkg::A_IPR0, ipr);
    pulse(7'h0, 40'h3);
    take(a);
    chain(b);
    idle();
  endtask

  task t_nmi();
    wr(epc_pkg::A_CTRL, 32'h3);
    take(6'h02);
    chain(6'h0e);
    idle();
  endtask

  // Only the group part may pre-empt a running handler
  task t_group(input logic [31:0] g);
    wr(epc_pkg::A_GROUP, g);
    wr(epc_pkg::A_IPR0, 32'h12);
    dly <= 8'd40;
    pulse(7'h0, 40'h1);
    take(6'h10);
    pulse(7'h0, 40'h2);
    if (g == 0) take(6'h11);
    else quiet();
    idle();
  endtask

  task t_reserved();
    wr(epc_pkg::A_EN_LO, 32'hffffffff);
    wr(epc_pkg::A_EN_HI, 32'hff);
    rd(epc_pkg::A_EN_LO, epc_pkg::IRQ_IMPL[31:0]);
    rd(epc_pkg::A_EN_HI, {24'h0, epc_pkg::IRQ_IMPL[39:32]});
    pulse(7'h0, 40'h200);
    quiet();
    rd(epc_pkg::A_PEND_LO, 0);
    @(posedge CLOCK);
    halt <= 1'b1;
    pulse(7'h10, 40'h0);
    quiet();
  endtask

  // -------------------------------------------------------------
  // Clock, main sequence, watchdog
  // -------------------------------------------------------------
  initial begin
    CLOCK = 1'b0;
    forever #20 CLOCK = ~CLOCK;
  end

  initial begin
    {HSEL, HWRITE, halt, HADDR, HWDATA, HTRANS, IRQ_IN, ev} = '0;
    HSIZE   = 3'h2;
    dly     = 8'd14;
    SYS_RST = 1'b1;
    vt = '{6'h04, 6'h05, 6'h06, 6'h0b, 6'h0c, 6'h0f, 6'h05};
    repeat (16) @(posedge CLOCK);
    chk("exc_in_reset", 1, EXC_NUM);
    SYS_RST <= 1'b0;
    repeat (2) @(posedge CLOCK);
    #1;
    chk("exc_after_boot", 0, EXC_NUM);
    t_reset();
    t_faults();
    t_reserved();
    t_tie(32'h0, 6'h10, 6'h11);
    t_tie(32'h1, 6'h11, 6'h10);
    t_nmi();
    t_group(2);
    t_group(0);
    conclude();
  end

  // Whole run needs about a thousand cycles; cut off at ten thousand
  initial begin
    #400000;
    n_errors++;
    conclude();
  end
endmodule
